/* File: design/cpu_programmer_registers.sv */
// Purpose: programmer-visible cpu registers with their update logic
// Assumes: memory answers a read in the same cycle as the read strobe
// Notes:   one command per cycle in the run state; busy otherwise
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_defines.svh"

// Contract
// - sum_register is 8-bit, feeds the alu, takes most results
// - reset leaves sum_register untouched
// - pointer pair is upper:lower; indexed modes use all 16 bits
// - some compatibility commands touch only lower byte, upper kept
// - lower byte also clears, steps, complements, negates, shifts, rotates
// - reset zeroes upper byte and keeps lower byte
// - stack_pointer is 16-bit, points at next free stack location
// - reset loads stack_pointer with 0x00ff
// - stack_adjust_immediate adds sign-extended 8-bit immediate to stack_pointer
// - stack_low_reload changes only the stack_pointer low byte
// - calls push return address; interrupts push it plus cpu registers
// - program_counter is 16-bit and steps once per fetched byte
// - jump, branch, interrupt, return load a non-sequential program_counter
// - after reset program_counter loads the vector at 0xfffe/0xffff
// - registers have no memory address, only command access
// - one 64-kbyte space addressed by 16 bits
// - direct addressing reaches only page zero with one address byte
// - relative addressing uses an 8-bit signed offset
// - immediate operand is the byte following the opcode
// - five indexed submodes off the pointer pair, two post-increment
// - 8x8 multiply and 16/8 divide
// - taken branch adds sign-extended offset to current program_counter
module cpu_programmer_registers
    import cpu_regs_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce,
    input  wire op_t         i_op,
    input  wire unary_t      i_unary,
    input  wire mode_t       i_mode,
    input  wire logic [7:0]  i_data8,
    input  wire logic [15:0] i_data16,
    input  wire logic        i_cond,
    input  wire logic        i_carry,
    input  wire logic [7:0]  i_mem_rdata,
    output logic [7:0]       o_sum,
    output logic [7:0]       o_upper,
    output logic [7:0]       o_lower,
    output logic [15:0]      o_pair,
    output logic [15:0]      o_stack,
    output logic [15:0]      o_pc,
    output logic [15:0]      o_ea,
    output logic             o_carry,
    output logic             o_div_fault,
    output logic [7:0]       o_flags,
    output logic [15:0]      o_mem_addr,
    output logic [7:0]       o_mem_wdata,
    output logic             o_mem_rd,
    output logic             o_mem_wr,
    output logic             o_busy
);

    // =================================================================
    // state
    regs_t r_reg;
    regs_t r_next;

    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[7]}}, v};
    endfunction

    logic [15:0] pair;
    logic [15:0] product;
    logic [15:0] quot;
    logic [7:0]  rem;
    logic [39:0] pulled;

    // registers live only here; the memory side never decodes them
    assign pair    = {r_reg.upper, r_reg.lower};
    assign product = 16'(r_reg.lower * r_reg.sum);
    assign quot    = (r_reg.lower == 8'h00) ? 16'hffff : pair_div();
    assign rem     = (r_reg.lower == 8'h00) ? 8'h00 : pair_rem();
    assign pulled  = {r_reg.shq[31:0], i_mem_rdata};

    function automatic logic [15:0] pair_div();
        pair_div = {r_reg.upper, r_reg.sum} / {8'h00, r_reg.lower};
    endfunction

    function automatic logic [7:0] pair_rem();
        logic [15:0] t;
        t = {r_reg.upper, r_reg.sum} % {8'h00, r_reg.lower};
        pair_rem = t[7:0];
    endfunction

    // =================================================================
    // next state
    always_comb
    begin
        r_next        = r_reg;
        r_next.mem_rd = 1'b0;
        r_next.mem_wr = 1'b0;
        case (r_reg.state)
            ST_VEC_HI:
            begin
                r_next.mem_addr = `VEC_ADDR_HI;
                r_next.mem_rd   = 1'b1;
                r_next.state    = ST_VEC_LO;
            end
            ST_VEC_LO:
            begin
                r_next.vec_hi   = i_mem_rdata;
                r_next.mem_addr = `VEC_ADDR_LO;
                r_next.mem_rd   = 1'b1;
                r_next.state    = ST_VEC_END;
            end
            ST_VEC_END:
            begin
                r_next.pc    = {r_reg.vec_hi, i_mem_rdata};
                r_next.state = ST_RUN;
            end
            ST_PUSH:
            begin
                r_next.mem_addr  = r_reg.sp;
                r_next.mem_wdata = r_reg.shq[7:0];
                r_next.mem_wr    = 1'b1;
                r_next.sp        = r_reg.sp - 16'h0001;
                r_next.shq       = {8'h00, r_reg.shq[39:8]};
                r_next.cnt       = r_reg.cnt - 3'h1;
                if (r_reg.cnt == 3'h1)
                begin
                    r_next.pc    = r_reg.target;
                    r_next.state = ST_RUN;
                end
            end
            ST_PULL_REQ:
            begin
                r_next.sp       = r_reg.sp + 16'h0001;
                r_next.mem_addr = r_reg.sp + 16'h0001;
                r_next.mem_rd   = 1'b1;
                r_next.state    = ST_PULL_CAP;
            end
            ST_PULL_CAP:
            begin
                r_next.shq   = pulled;
                r_next.cnt   = r_reg.cnt - 3'h1;
                r_next.state = ST_PULL_REQ;
                if (r_reg.cnt == 3'h1)
                begin
                    r_next.state = ST_RUN;
                    case (r_reg.kind)
                        PK_SUM:   r_next.sum   = pulled[7:0];
                        PK_LOWER: r_next.lower = pulled[7:0];
                        PK_RET:   r_next.pc    = pulled[15:0];
                        PK_RTI:
                        begin
                            // pulled order: flags, sum, lower, pc high, pc low
                            r_next.flags = pulled[39:32];
                            r_next.sum   = pulled[31:24];
                            r_next.lower = pulled[23:16];
                            r_next.pc    = pulled[15:0];
                        end
                        default: r_next.kind = r_reg.kind;
                    endcase
                end
            end
            ST_RUN:
            begin
                case (i_op)
                    OP_FETCH: r_next.pc = r_reg.pc + 16'h0001;
                    OP_JUMP:  r_next.pc = i_data16;
                    OP_BRANCH:
                    begin
                        if (i_cond)
                        begin
                            r_next.pc = r_reg.pc + sext8(i_data8);
                        end
                    end
                    OP_LD_SUM:   r_next.sum   = i_data8;
                    OP_LD_LOWER: r_next.lower = i_data8;
                    OP_LD_UPPER: r_next.upper = i_data8;
                    OP_LD_PAIR:
                    begin
                        r_next.upper = i_data16[15:8];
                        r_next.lower = i_data16[7:0];
                    end
                    OP_LD_STACK: r_next.sp = i_data16;
                    OP_LOWER_UNARY:
                    begin
                        // upper byte is never touched here
                        case (i_unary)
                            UN_CLR: r_next.lower = 8'h00;
                            UN_INC: r_next.lower = r_reg.lower + 8'h01;
                            UN_DEC: r_next.lower = r_reg.lower - 8'h01;
                            UN_COM: r_next.lower = ~r_reg.lower;
                            UN_NEG: r_next.lower = 8'h00 - r_reg.lower;
                            UN_LSL:
                            begin
                                r_next.carry = r_reg.lower[7];
                                r_next.lower = {r_reg.lower[6:0], 1'b0};
                            end
                            UN_LSR:
                            begin
                                r_next.carry = r_reg.lower[0];
                                r_next.lower = {1'b0, r_reg.lower[7:1]};
                            end
                            UN_ASR:
                            begin
                                r_next.carry = r_reg.lower[0];
                                r_next.lower = {r_reg.lower[7], r_reg.lower[7:1]};
                            end
                            UN_ROL:
                            begin
                                r_next.carry = r_reg.lower[7];
                                r_next.lower = {r_reg.lower[6:0], i_carry};
                            end
                            UN_ROR:
                            begin
                                r_next.carry = r_reg.lower[0];
                                r_next.lower = {i_carry, r_reg.lower[7:1]};
                            end
                            default: r_next.lower = r_reg.lower;
                        endcase
                    end
                    OP_STACK_ADJ: r_next.sp = r_reg.sp + sext8(i_data8);
                    OP_STACK_LOW_RELOAD:
                    begin
                        r_next.sp = {r_reg.sp[15:8], `STACK_LOW_VALUE};
                    end
                    OP_PUSH_SUM, OP_PUSH_LOWER:
                    begin
                        r_next.mem_addr  = r_reg.sp;
                        r_next.mem_wdata = (i_op == OP_PUSH_SUM) ? r_reg.sum : r_reg.lower;
                        r_next.mem_wr    = 1'b1;
                        r_next.sp        = r_reg.sp - 16'h0001;
                    end
                    OP_PULL_SUM, OP_PULL_LOWER:
                    begin
                        r_next.kind  = (i_op == OP_PULL_SUM) ? PK_SUM : PK_LOWER;
                        r_next.cnt   = `PULL_ONE_BYTE;
                        r_next.state = ST_PULL_REQ;
                    end
                    OP_CALL:
                    begin
                        // low byte goes first so it lands at the higher address
                        r_next.shq    = {24'h000000, r_reg.pc};
                        r_next.cnt    = `PUSH_CALL_BYTES;
                        r_next.target = i_data16;
                        r_next.state  = ST_PUSH;
                    end
                    OP_INTERRUPT:
                    begin
                        // flags byte comes in on i_data8; vector on i_data16
                        r_next.shq    = {i_data8, r_reg.sum, r_reg.lower, r_reg.pc};
                        r_next.cnt    = `PUSH_INT_BYTES;
                        r_next.target = i_data16;
                        r_next.state  = ST_PUSH;
                    end
                    OP_RETURN:
                    begin
                        r_next.kind  = PK_RET;
                        r_next.cnt   = `PULL_RET_BYTES;
                        r_next.shq   = 40'h0000000000;
                        r_next.state = ST_PULL_REQ;
                    end
                    OP_RETURN_INT:
                    begin
                        r_next.kind  = PK_RTI;
                        r_next.cnt   = `PULL_RTI_BYTES;
                        r_next.shq   = 40'h0000000000;
                        r_next.state = ST_PULL_REQ;
                    end
                    OP_MUL:
                    begin
                        r_next.lower = product[15:8];
                        r_next.sum   = product[7:0];
                        r_next.carry = 1'b0;
                    end
                    OP_DIV:
                    begin
                        // overflow or zero divisor keeps the operands intact
                        if (quot[15:8] != 8'h00)
                        begin
                            r_next.div_fault = 1'b1;
                            r_next.carry     = 1'b1;
                        end
                        else
                        begin
                            r_next.div_fault = 1'b0;
                            r_next.carry     = 1'b0;
                            r_next.sum       = quot[7:0];
                            r_next.upper     = rem;
                        end
                    end
                    OP_EA:
                    begin
                        case (i_mode)
                            MD_IMMEDIATE:
                            begin
                                r_next.ea = r_reg.pc;
                                r_next.pc = r_reg.pc + 16'h0001;
                            end
                            MD_DIRECT:   r_next.ea = {`DIRECT_PAGE, i_data8};
                            MD_EXTENDED: r_next.ea = i_data16;
                            MD_IX:       r_next.ea = pair;
                            MD_IX8:      r_next.ea = pair + {8'h00, i_data8};
                            MD_IX16:     r_next.ea = pair + i_data16;
                            MD_IX_POSTINC:
                            begin
                                r_next.ea = pair;
                                {r_next.upper, r_next.lower} = pair + 16'h0001;
                            end
                            MD_IX8_POSTINC:
                            begin
                                r_next.ea = pair + {8'h00, i_data8};
                                {r_next.upper, r_next.lower} = pair + 16'h0001;
                            end
                            MD_SP8:      r_next.ea = r_reg.sp + {8'h00, i_data8};
                            MD_RELATIVE: r_next.ea = r_reg.pc + sext8(i_data8);
                            default:     r_next.ea = r_reg.ea;
                        endcase
                    end
                    default: r_next.state = ST_RUN;
                endcase
            end
            default: r_next.state = ST_VEC_HI;
        endcase

        if (!i_rst_b)
        begin
            // sum and lower keep their value through reset
            r_next.state     = ST_VEC_HI;
            r_next.upper     = `UPPER_RESET;
            r_next.sp        = `STACK_RESET;
            r_next.pc        = `PC_RESET;
            r_next.ea        = 16'h0000;
            r_next.carry     = 1'b0;
            r_next.div_fault = 1'b0;
            r_next.flags     = 8'h00;
            r_next.mem_addr  = 16'h0000;
            r_next.mem_wdata = 8'h00;
            r_next.mem_rd    = 1'b0;
            r_next.mem_wr    = 1'b0;
            r_next.shq       = 40'h0000000000;
            r_next.cnt       = 3'h0;
            r_next.target    = 16'h0000;
            r_next.kind      = PK_SUM;
            r_next.vec_hi    = 8'h00;
        end
    end

    // =================================================================
    // registers
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b || i_ce)
        begin
            r_reg <= r_next;
        end
    end

    // =================================================================
    // outputs
    assign o_sum       = r_reg.sum;
    assign o_upper     = r_reg.upper;
    assign o_lower     = r_reg.lower;
    assign o_pair      = pair;
    assign o_stack     = r_reg.sp;
    assign o_pc        = r_reg.pc;
    assign o_ea        = r_reg.ea;
    assign o_carry     = r_reg.carry;
    assign o_div_fault = r_reg.div_fault;
    assign o_flags     = r_reg.flags;
    assign o_mem_addr  = r_reg.mem_addr;
    assign o_mem_wdata = r_reg.mem_wdata;
    assign o_mem_rd    = r_reg.mem_rd;
    assign o_mem_wr    = r_reg.mem_wr;
    assign o_busy      = (r_reg.state != ST_RUN);

endmodule
`default_nettype wire

/* File: design/cpu_regs_defines.svh */
// Purpose: constants of the cpu programmer register block
// Assumes: included by bare name
// Notes:   fixed addresses, reset values and byte counts only
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH

// =====================================================================
// reset values
`define UPPER_RESET       8'h00
`define STACK_RESET       16'h00ff
`define PC_RESET          16'h0000

// =====================================================================
// fixed addresses
`define VEC_ADDR_HI       16'hfffe
`define VEC_ADDR_LO       16'hffff
`define DIRECT_PAGE       8'h00
`define STACK_LOW_VALUE   8'hff

// =====================================================================
// stack sequence lengths in bytes
`define PUSH_CALL_BYTES   3'h2
`define PUSH_INT_BYTES    3'h5
`define PULL_ONE_BYTE     3'h1
`define PULL_RET_BYTES    3'h2
`define PULL_RTI_BYTES    3'h5

`endif

/* File: design/cpu_regs_pkg.sv */
// Purpose: types of the cpu programmer register block
// Assumes: one clock, one synchronous reset
// Notes:   all state of the block is one packed struct
package cpu_regs_pkg;

    // =================================================================
    // commands
    typedef enum logic [4:0] {
        OP_NOP              = 5'h00,
        OP_FETCH            = 5'h01,
        OP_JUMP             = 5'h02,
        OP_BRANCH           = 5'h03,
        OP_LD_SUM           = 5'h04,
        OP_LD_LOWER         = 5'h05,
        OP_LD_UPPER         = 5'h06,
        OP_LD_PAIR          = 5'h07,
        OP_LD_STACK         = 5'h08,
        OP_LOWER_UNARY      = 5'h09,
        OP_STACK_ADJ        = 5'h0a,
        OP_STACK_LOW_RELOAD = 5'h0b,
        OP_PUSH_SUM         = 5'h0c,
        OP_PUSH_LOWER       = 5'h0d,
        OP_PULL_SUM         = 5'h0e,
        OP_PULL_LOWER       = 5'h0f,
        OP_CALL             = 5'h10,
        OP_INTERRUPT        = 5'h11,
        OP_RETURN           = 5'h12,
        OP_RETURN_INT       = 5'h13,
        OP_MUL              = 5'h14,
        OP_DIV              = 5'h15,
        OP_EA               = 5'h16
    } op_t;

    typedef enum logic [3:0] {
        UN_CLR = 4'h0,
        UN_INC = 4'h1,
        UN_DEC = 4'h2,
        UN_COM = 4'h3,
        UN_NEG = 4'h4,
        UN_LSL = 4'h5,
        UN_LSR = 4'h6,
        UN_ASR = 4'h7,
        UN_ROL = 4'h8,
        UN_ROR = 4'h9
    } unary_t;

    typedef enum logic [3:0] {
        MD_IMMEDIATE   = 4'h0,
        MD_DIRECT      = 4'h1,
        MD_EXTENDED    = 4'h2,
        MD_IX          = 4'h3,
        MD_IX8         = 4'h4,
        MD_IX16        = 4'h5,
        MD_IX_POSTINC  = 4'h6,
        MD_IX8_POSTINC = 4'h7,
        MD_SP8         = 4'h8,
        MD_RELATIVE    = 4'h9
    } mode_t;

    typedef enum logic [2:0] {
        ST_VEC_HI   = 3'h0,
        ST_VEC_LO   = 3'h1,
        ST_VEC_END  = 3'h2,
        ST_RUN      = 3'h3,
        ST_PUSH     = 3'h4,
        ST_PULL_REQ = 3'h5,
        ST_PULL_CAP = 3'h6
    } state_t;

    typedef enum logic [1:0] {
        PK_SUM   = 2'h0,
        PK_LOWER = 2'h1,
        PK_RET   = 2'h2,
        PK_RTI   = 2'h3
    } pull_kind_t;

    typedef struct packed {
        state_t     state;
        logic [7:0]  sum;
        logic [7:0]  upper;
        logic [7:0]  lower;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [15:0] ea;
        logic        carry;
        logic        div_fault;
        logic [7:0]  flags;
        logic [15:0] mem_addr;
        logic [7:0]  mem_wdata;
        logic        mem_rd;
        logic        mem_wr;
        logic [39:0] shq;
        logic [2:0]  cnt;
        logic [15:0] target;
        pull_kind_t  kind;
        logic [7:0]  vec_hi;
    } regs_t;

endpackage

/* File: tb/cpu_mem_model.sv */
// Purpose: memory on the far side of the cpu register block
// Assumes: read data is shown while the read strobe stands
// Notes:   a released data bus shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module cpu_mem_model
(
    input  wire logic        i_clk,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    output logic [7:0]       o_rdata
);
    // ==========
    // storage
    logic [7:0] mem [0:65535];
    logic [7:0] last_reg = 8'h00;
    initial
    begin
        mem[16'hfffe] = 8'h12;
        mem[16'hffff] = 8'h34;
    end
    always @(posedge i_clk)
    begin
        if (i_wr) mem[i_addr] <= i_wdata;
        if (i_rd) last_reg <= o_rdata;
    end
    // inverse, not a held value, so a late sample cannot pass by luck
    assign o_rdata = i_rd ? mem[i_addr] : ~last_reg;
endmodule
`default_nettype wire

/* File: tb/cpu_programmer_registers_sva.sv */
// Purpose: port checks of the cpu register block
// Assumes: one clock, synchronous active-low reset
// Notes:   commands count only when enabled and not busy
`timescale 1ns/1ps
`default_nettype none
module cpu_programmer_registers_sva
    import cpu_regs_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_ce,
    input wire op_t         i_op,
    input wire logic [7:0]  i_data8,
    input wire logic [15:0] i_data16,
    input wire logic        i_cond,
    input wire logic [15:0] o_pair,
    input wire logic [15:0] o_stack,
    input wire logic [15:0] o_pc,
    input wire logic [15:0] o_mem_addr,
    input wire logic        o_mem_rd,
    input wire logic        o_mem_wr,
    input wire logic        o_busy
);
    // ==========
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic take;
    assign take = i_ce && !o_busy;
    reset_values_a: assert property ($rose(i_rst_b) |-> o_stack == 16'h00ff
        && o_pair[15:8] == 8'h00) else $error("bad reset values");
    vector_read_a: assert property ($rose(i_rst_b) |=> o_mem_rd && o_mem_addr == 16'hfffe
        ##1 o_mem_rd && o_mem_addr == 16'hffff) else $error("bad vector read");
    fetch_step_a: assert property (take && i_op == OP_FETCH |=> o_pc == $past(o_pc) + 16'h1)
        else $error("bad fetch step");
    jump_load_a: assert property (take && i_op == OP_JUMP |=> o_pc == $past(i_data16))
        else $error("bad jump");
    branch_take_a: assert property (take && i_op == OP_BRANCH && i_cond |=> o_pc ==
        $past(o_pc) + {{8{$past(i_data8[7])}}, $past(i_data8)}) else $error("bad branch");
    stack_adj_a: assert property (take && i_op == OP_STACK_ADJ |=> o_stack ==
        $past(o_stack) + {{8{$past(i_data8[7])}}, $past(i_data8)}) else $error("bad adjust");
    low_reload_a: assert property (take && i_op == OP_STACK_LOW_RELOAD |=>
        o_stack == {$past(o_stack[15:8]), 8'hff}) else $error("bad low reload");
    push_order_a: assert property (take && i_op == OP_PUSH_SUM |=> o_mem_wr &&
        o_mem_addr == $past(o_stack) && o_stack == $past(o_stack) - 16'h1) else $error("bad push");
    upper_kept_a: assert property (take && i_op == OP_LD_LOWER |=>
        o_pair[15:8] == $past(o_pair[15:8])) else $error("upper byte changed");
    call_cov: cover property (take && i_op == OP_CALL);
    branch_cov: cover property (take && i_op == OP_BRANCH && i_cond);
    reset_cov: cover property ($rose(i_rst_b));
endmodule
bind cpu_programmer_registers cpu_programmer_registers_sva sva_u (.i_clk, .i_rst_b, .i_ce,
    .i_op, .i_data8, .i_data16, .i_cond, .o_pair, .o_stack, .o_pc, .o_mem_addr, .o_mem_rd,
    .o_mem_wr, .o_busy);
`default_nettype wire

/* File: tb/cpu_programmer_registers_tb.sv */
// Purpose: scenario bench of the cpu register block
// Assumes: memory model holds the vector 0x1234
// Notes:   byte loads use the low half
`timescale 1ns/1ps
`default_nettype none
module cpu_programmer_registers_tb
    import cpu_regs_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_ce = 1'b1;
    logic        i_cond = 1'b0;
    logic        i_carry = 1'b1;
    op_t         i_op = OP_NOP;
    unary_t      i_unary = UN_CLR;
    mode_t       i_mode = MD_IX;
    logic [7:0]  i_data8 = 8'h00;
    logic [15:0] i_data16 = 16'h0000;
    logic [7:0]  i_mem_rdata, o_sum, o_upper, o_lower, o_flags, o_mem_wdata;
    logic [15:0] o_pair, o_stack, o_pc, o_ea, o_mem_addr;
    logic        o_carry, o_div_fault, o_mem_rd, o_mem_wr, o_busy;
    int          fail_count = 0, checked = 0, cycles = 0;
    unary_t      un = UN_CLR;
    logic        cnd = 1'b0;
    mode_t       md = MD_DIRECT;
    localparam logic [79:0] UN_EXP = 80'h0082807e7f0240c003c0;
    always #20 i_clk = ~i_clk;
    cpu_programmer_registers dut_u (.i_clk, .i_rst_b, .i_ce, .i_op, .i_unary, .i_mode,
        .i_data8, .i_data16, .i_cond, .i_carry, .i_mem_rdata, .o_sum, .o_upper, .o_lower,
        .o_pair, .o_stack, .o_pc, .o_ea, .o_carry, .o_div_fault, .o_flags, .o_mem_addr,
        .o_mem_wdata, .o_mem_rd, .o_mem_wr, .o_busy);
    cpu_mem_model mem_u (.i_clk, .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
        .i_rd(o_mem_rd), .i_wr(o_mem_wr), .o_rdata(i_mem_rdata));
    // ==========
    // helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // bounded: a stuck busy gives up after 40 cycles instead of hanging
    task automatic settle;
        int n;
        n = 0;
        #1;
        while (o_busy !== 1'b0 && n < 40)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
    endtask
    task automatic do_reset;
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        settle();
    endtask
    task automatic cmd(input op_t op, input logic [15:0] val);
        @(posedge i_clk);
        i_op <= op;
        i_data8 <= val[7:0];
        i_data16 <= val;
        i_unary <= un;
        i_cond <= cnd;
        i_mode <= md;
        @(posedge i_clk);
        i_op <= OP_NOP;
        settle();
    endtask
    // ==========
    // scenarios
    task automatic t_reset;
        cmd(OP_LD_SUM, 16'h005a);
        cmd(OP_LD_LOWER, 16'h00a5);
        cmd(OP_LD_UPPER, 16'h0077);
        do_reset();
        chk(o_pc, 16'h1234);
        chk(o_stack, 16'h00ff);
        chk(o_pair, 16'h00a5);
        chk({8'h00, o_sum}, 16'h005a);
    endtask
    task automatic t_flow;
        cmd(OP_JUMP, 16'h8000);
        chk(o_pc, 16'h8000);
        cmd(OP_FETCH, 16'h0000);
        chk(o_pc, 16'h8001);
        cnd = 1'b1;
        cmd(OP_BRANCH, 16'h00fd);
        chk(o_pc, 16'h7ffe);
        cnd = 1'b0;
    endtask
    task automatic t_stack;
        cmd(OP_LD_STACK, 16'h0200);
        cmd(OP_STACK_ADJ, 16'h0080);
        chk(o_stack, 16'h0180);
        cmd(OP_STACK_LOW_RELOAD, 16'h0000);
        chk(o_stack, 16'h01ff);
        cmd(OP_LD_SUM, 16'h003c);
        cmd(OP_PUSH_SUM, 16'h0000);
        cmd(OP_LD_SUM, 16'h0000);
        chk({o_stack[7:0], mem_u.mem[16'h01ff]}, 16'hfe3c);
        cmd(OP_PULL_SUM, 16'h0000);
        chk({o_stack[7:0], o_sum}, 16'hff3c);
    endtask
    task automatic t_call;
        cmd(OP_LD_STACK, 16'h0300);
        cmd(OP_JUMP, 16'h4321);
        cmd(OP_CALL, 16'h9000);
        chk(o_pc, 16'h9000);
        cmd(OP_RETURN, 16'h0000);
        chk({mem_u.mem[16'h0300], mem_u.mem[16'h02ff]}, 16'h2143);
        chk(o_pc, 16'h4321);
        chk(o_stack, 16'h0300);
    endtask
    task automatic t_lower;
        cmd(OP_LD_PAIR, 16'hbeef);
        chk(o_pair, 16'hbeef);
        for (int k = 0; k < 10; k++)
        begin
            un = unary_t'(k);
            cmd(OP_LD_LOWER, 16'h0081);
            cmd(OP_LOWER_UNARY, 16'h0000);
            chk(o_pair, {8'hbe, UN_EXP[79-8*k -: 8]});
        end
    endtask
    task automatic t_alu;
        cmd(OP_EA, 16'hab80);
        chk(o_ea, 16'h0080);
        cmd(OP_LD_PAIR, 16'h0010);
        cmd(OP_MUL, 16'h0000);
        chk({o_lower, o_sum}, 16'h03c0);
        cmd(OP_DIV, 16'h0000);
        chk({o_div_fault, o_carry, o_sum}, 16'h0040);
        cmd(OP_LD_LOWER, 16'h0000);
        cmd(OP_DIV, 16'h0000);
        chk({o_div_fault, o_carry, o_sum}, 16'h0340);
        md = MD_IX8_POSTINC;
        cmd(OP_LD_PAIR, 16'h12ff);
        cmd(OP_EA, 16'h0010);
        chk(o_ea, 16'h130f);
        chk(o_pair, 16'h1300);
    endtask
    // ==========
    // run control
    task automatic final_report;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            final_report();
        end
    end
    initial
    begin
        do_reset();
        t_reset();
        t_flow();
        t_stack();
        t_call();
        t_lower();
        t_alu();
        final_report();
    end
endmodule
`default_nettype wire
